// ### design/cps_edge_sync.sv
`default_nettype none
module cps_edge_sync
  import cps_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  initial begin
    if (W < 1) $error("cps_edge_sync: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } cps_sync_s;

  cps_sync_s st;
  cps_sync_s next_st;

  // ------------------------------------------------------------
  // Two-stage synchroniser, third stage for edge finding
  // ------------------------------------------------------------
  // Only s2 reads s1, so no logic sees a metastable value
  always_comb begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Edge and level views of the synchronised stage
  assign dout = st.s2;
  assign rise = st.s2 & ~st.s3;
  assign fall = ~st.s2 & st.s3;

endmodule
`default_nettype wire

// ### design/cps_pkg.sv
`default_nettype none
package cps_pkg;

  // ------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ------------------------------------------------------------
  localparam logic [7:0] CPS_OFF_CTRL     = 8'h00;
  localparam logic [7:0] CPS_OFF_LOCKMASK = 8'h04;
  localparam logic [7:0] CPS_OFF_STATUS   = 8'h08;
  localparam logic [7:0] CPS_OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] CPS_OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] CPS_OFF_ADDR     = 8'h14;
  localparam logic [7:0] CPS_OFF_ACLK     = 8'h18;
  localparam logic [7:0] CPS_OFF_FRAME    = 8'h1c;

  // ------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------
  localparam int CPS_CTRL_AUX_EN   = 0;
  localparam int CPS_CTRL_FMT_LSB  = 4;
  localparam int CPS_CTRL_FMT_W    = 2;

  // ------------------------------------------------------------
  // Frame pulse formats
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CPS_FMT_AVF   = 2'b00,
    CPS_FMT_SYNC  = 2'b01,
    CPS_FMT_ALIGN = 2'b10,
    CPS_FMT_OFF   = 2'b11
  } cps_fmt_e;

  // ------------------------------------------------------------
  // Bus target addresses, strap codes, reset values
  // ------------------------------------------------------------
  localparam logic [6:0] CPS_ADDR_LOW   = 7'h65;
  localparam logic [6:0] CPS_ADDR_FLOAT = 7'h66;
  localparam logic [6:0] CPS_ADDR_HIGH  = 7'h67;
  localparam logic [3:0] CPS_ACLK_DIV_RST = 4'h2;   // 98.304 / 2^(2+1) = 12.288 MHz
  localparam logic [15:0] CPS_FRAME_LEN_RST = 16'h0400;
  localparam logic [1:0] CPS_IRQ_W = 2'd3;
  localparam int CPS_STRAP_WAIT = 2;   // Synchroniser stages before the strap is valid

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CPS_PCLK_MHZ      = 50;
  localparam int CPS_PULSE_NS      = 100;
  localparam int CPS_PULSE_CYC     = (CPS_PULSE_NS * CPS_PCLK_MHZ + 999) / 1000;
  localparam int CPS_POL_WIN       = 255;

endpackage
`default_nettype wire

// ### design/cps_top.sv
`default_nettype none
// Contract
// - Three-state address pin picks target 0x65 low, 0x66 float, 0x67 high.
// - Unlock flag is high while any of four PLLs lost lock.
// - Unlock flag built from lock bits; masked PLLs do not contribute.
// - Misalignment flag high while any of four frame outputs lost alignment.
// - Reference lost flag high when reference lost, low when valid.
// - Alignment reset starts on trigger rising edge only, never on level.
// - Detect horizontal sync polarity, correct all three sync inputs by it.
// - Any recognised clock format is accepted on horizontal sync input; the code has no clock-format detection, and each rising edge clears h_pol.
// - Fourth frame pin gives active-low audio pulse, format host programmable.
// - Fourth frame pin is clock input only after host enables it.
// - Audio clock from 98.304 MHz fundamental, default 24.576 MHz, host selectable; the reset divider gives 12.288 MHz.
module cps_top
  import cps_pkg::*;
#(
  parameter int FRAME_W = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        addr_sel_in,
  input  wire logic        addr_sel_oe_n,
  input  wire logic        h_sync_in,
  input  wire logic        v_sync_in,
  input  wire logic        f_sync_in,
  input  wire logic        align_trig_in,
  input  wire logic [3:0]  pll_lock_bits,
  input  wire logic [3:0]  frame_align_ok,
  input  wire logic        ref_valid,
  input  wire logic        audio_pll_clk_tick,
  input  wire logic        aux_osc_in,
  output logic             audio_frame_pulse_out,
  output logic             audio_frame_pulse_oe_n,
  output logic             audio_clock_out,
  output logic             aux_clock_tick,
  output logic             sync_triplet_h,
  output logic             sync_triplet_v,
  output logic             sync_triplet_f,
  output logic             align_reset_pulse,
  output logic             no_lock,
  output logic             no_align,
  output logic             no_ref,
  output logic      [6:0]  bus_target_addr
);

  initial begin
    if (FRAME_W < 4 || FRAME_W > 16) $error("cps_top: FRAME_W must be 4..16");
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Strap pin, its float detector, sync triplet, trigger, aux clock
  localparam int NS = 7;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] pin_lvl;
  logic [NS-1:0] pin_rise;

  assign pin_raw = {aux_osc_in, align_trig_in, f_sync_in, v_sync_in, h_sync_in,
                    addr_sel_oe_n, addr_sel_in};

  cps_edge_sync #(.W(NS)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (pin_raw),
    .dout    (pin_lvl),
    .rise    (pin_rise),
    .fall    ()
  );

  // Decode of a three-state strap: float is flagged by the pad keeper
  function automatic logic [6:0] cps_addr_decode(input logic lvl, input logic flt);
    if (flt) begin
      cps_addr_decode = CPS_ADDR_FLOAT;
    end else if (lvl) begin
      cps_addr_decode = CPS_ADDR_HIGH;
    end else begin
      cps_addr_decode = CPS_ADDR_LOW;
    end
  endfunction

  // Register write strobe for one offset
  function automatic logic cps_wr_hit(input logic [7:0] a, input logic [7:0] off,
                                      input logic wr);
    cps_wr_hit = wr && (a == off);
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic                 aux_en;
    logic [1:0]           fmt;
    logic [3:0]           lock_mask;
    logic [3:0]           aclk_div;
    logic [FRAME_W-1:0]   frame_len;
    logic [2:0]           irq_stat;
    logic [2:0]           irq_mask;
    logic                 strap_done;
    logic [1:0]           strap_wait;
    logic [6:0]           addr;
    logic                 no_lock;
    logic                 no_align;
    logic                 no_ref;
    logic                 h_pol;
    logic [7:0]           pol_cnt;
    logic                 align_pulse;
    logic [FRAME_W-1:0]   frame_cnt;
    logic [7:0]           pulse_cnt;
    logic                 frame_out;
    logic [14:0]          aclk_cnt;
    logic                 aclk;
    logic [31:0]          rdata;
  } cps_state_s;

  cps_state_s st;
  cps_state_s next_st;

  logic       wr_en;
  logic       rd_en;
  logic       bad_addr;
  logic       lock_any;
  logic       align_any;
  logic [2:0] ev;
  logic       pll_tick;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign bad_addr = paddr[1:0] != 2'b00 || paddr > CPS_OFF_FRAME;

  // Masked bits drop out of the unlock flag
  assign lock_any  = |(~pll_lock_bits & ~st.lock_mask);
  assign align_any = |(~frame_align_ok);
  assign ev        = {!ref_valid, align_any, lock_any};

  // Pulse clock: aux oscillator only when host enabled it
  assign pll_tick = st.aux_en ? pin_rise[6] : audio_pll_clk_tick;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;

    // Strap caught once, after the synchroniser has filled with pin levels;
    // an earlier sample would only see the synchroniser's reset zeros
    if (!st.strap_done) begin
      if (st.strap_wait == 2'(CPS_STRAP_WAIT)) begin
        next_st.addr       = cps_addr_decode(pin_lvl[0], pin_lvl[1]);
        next_st.strap_done = 1'b1;
      end else begin
        next_st.strap_wait = st.strap_wait + 2'h1;
      end
    end

    // Flags registered so the pins never glitch
    next_st.no_lock  = lock_any;
    next_st.no_align = align_any;
    next_st.no_ref   = !ref_valid;

    // Polarity: the line is sampled once per window; low then sets h_pol, high then clears it.
    // Clock formats on the same pin are not measured; each rising edge clears h_pol.
    if (st.pol_cnt == 8'(CPS_POL_WIN)) begin
      next_st.pol_cnt = '0;
    end else begin
      next_st.pol_cnt = st.pol_cnt + 8'h01;
    end
    if (pin_rise[2]) begin
      next_st.h_pol = 1'b0;
    end
    if (st.pol_cnt == 8'h00 && !pin_lvl[2]) begin
      next_st.h_pol = 1'b1;
    end
    if (pin_lvl[2] && st.pol_cnt == 8'h00) begin
      next_st.h_pol = 1'b0;
    end

    // Alignment reset on rising edge only
    next_st.align_pulse = pin_rise[5];

    // Frame pulse counter on pll_tick: audio PLL tick, or aux clock when enabled
    if (st.align_pulse) begin
      next_st.frame_cnt = '0;
    end else if (pll_tick) begin
      if (st.frame_cnt >= st.frame_len - FRAME_W'(1)) begin
        next_st.frame_cnt = '0;
        next_st.pulse_cnt = 8'(CPS_PULSE_CYC);
      end else begin
        next_st.frame_cnt = st.frame_cnt + FRAME_W'(1);
      end
    end
    if (st.pulse_cnt != 8'h00) begin
      next_st.pulse_cnt = st.pulse_cnt - 8'h01;
    end
    case (cps_fmt_e'(st.fmt))
      CPS_FMT_AVF:   next_st.frame_out = !(st.pulse_cnt != 8'h00);
      CPS_FMT_SYNC:  next_st.frame_out = !(pin_lvl[3] ^ st.h_pol);
      CPS_FMT_ALIGN: next_st.frame_out = !st.align_pulse;
      default:       next_st.frame_out = 1'b1;
    endcase

    // Audio clock divider: half-period of 2^div PLL ticks
    if (audio_pll_clk_tick) begin
      if (st.aclk_cnt >= (15'h0001 << st.aclk_div) - 15'h0001) begin
        next_st.aclk_cnt = '0;
        next_st.aclk     = !st.aclk;
      end else begin
        next_st.aclk_cnt = st.aclk_cnt + 15'h0001;
      end
    end

    // Interrupt status: set wins over write-one clear
    next_st.irq_stat = st.irq_stat;
    if (cps_wr_hit(paddr, CPS_OFF_IRQ_STAT, wr_en) && pstrb[0]) begin
      next_st.irq_stat = st.irq_stat & ~pwdata[2:0];
    end
    next_st.irq_stat = next_st.irq_stat | ev;

    // Register writes; a transfer is taken in the access cycle
    if (wr_en && pstrb[0]) begin
      if (cps_wr_hit(paddr, CPS_OFF_CTRL, wr_en)) begin
        next_st.aux_en = pwdata[CPS_CTRL_AUX_EN];
        next_st.fmt    = pwdata[CPS_CTRL_FMT_LSB +: CPS_CTRL_FMT_W];
      end else if (cps_wr_hit(paddr, CPS_OFF_LOCKMASK, wr_en)) begin
        next_st.lock_mask = pwdata[3:0];
      end else if (cps_wr_hit(paddr, CPS_OFF_IRQ_MASK, wr_en)) begin
        next_st.irq_mask = pwdata[2:0];
      end else if (cps_wr_hit(paddr, CPS_OFF_ACLK, wr_en)) begin
        next_st.aclk_div = pwdata[3:0];
      end
    end
    if (cps_wr_hit(paddr, CPS_OFF_FRAME, wr_en) && pstrb[1:0] == 2'b11) begin
      next_st.frame_len = pwdata[FRAME_W-1:0];
    end

    // Read data registered at the setup edge, so it stands through the access cycle
    next_st.rdata = '0;
    if (rd_en) begin
      if (paddr == CPS_OFF_CTRL) begin
        next_st.rdata = 32'({st.fmt, 3'b000, st.aux_en});
      end else if (paddr == CPS_OFF_LOCKMASK) begin
        next_st.rdata = 32'(st.lock_mask);
      end else if (paddr == CPS_OFF_STATUS) begin
        next_st.rdata = 32'({st.h_pol, pll_lock_bits, st.no_ref, st.no_align, st.no_lock});
      end else if (paddr == CPS_OFF_IRQ_STAT) begin
        next_st.rdata = 32'(st.irq_stat);
      end else if (paddr == CPS_OFF_IRQ_MASK) begin
        next_st.rdata = 32'(st.irq_mask);
      end else if (paddr == CPS_OFF_ADDR) begin
        next_st.rdata = 32'(st.addr);
      end else if (paddr == CPS_OFF_ACLK) begin
        next_st.rdata = 32'(st.aclk_div);
      end else if (paddr == CPS_OFF_FRAME) begin
        next_st.rdata = 32'(st.frame_len);
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st           <= '0;
      st.aclk_div  <= CPS_ACLK_DIV_RST;
      st.frame_len <= FRAME_W'(CPS_FRAME_LEN_RST);
      st.addr      <= CPS_ADDR_LOW;
      st.irq_stat  <= '0;
      st.frame_out <= 1'b1;
      st.no_ref    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Zero wait states: pready is combinational, data is already in its flop
  assign pready  = 1'b1;
  assign pslverr = psel && penable && bad_addr;
  assign prdata  = st.rdata;
  assign irq     = |(st.irq_stat & st.irq_mask);

  // Pin is released (oe_n high) while it serves as aux clock input
  assign audio_frame_pulse_out  = st.frame_out;
  assign audio_frame_pulse_oe_n = st.aux_en;
  assign aux_clock_tick         = st.aux_en & pin_rise[6];
  assign audio_clock_out        = st.aclk;
  assign sync_triplet_h         = pin_lvl[2] ^ st.h_pol;
  assign sync_triplet_v         = pin_lvl[3] ^ st.h_pol;
  assign sync_triplet_f         = pin_lvl[4] ^ st.h_pol;
  assign align_reset_pulse      = st.align_pulse;
  assign no_lock                = st.no_lock;
  assign no_align               = st.no_align;
  assign no_ref                 = st.no_ref;
  assign bus_target_addr        = st.addr;

endmodule
`default_nettype wire

// ### verification/cps_far_end.sv
`default_nettype none
module cps_far_end (
  input  wire logic run,
  output logic      aux_osc_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Aux oscillator, 160 ns, off-phase to pclk; parked low between runs
  initial begin
    aux_osc_in = 1'b0;
    #37;
    forever begin
      #80;
      aux_osc_in = run ? ~aux_osc_in : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verification/cps_top_props.sv
`default_nettype none
module cps_props
  import cps_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [3:0] pll_lock_bits,
  input wire logic [3:0] frame_align_ok,
  input wire logic       ref_valid,
  input wire logic       no_lock,
  input wire logic       no_align,
  input wire logic       no_ref,
  input wire logic       align_trig_in,
  input wire logic       align_reset_pulse,
  input wire logic       addr_sel_in,
  input wire logic       addr_sel_oe_n,
  input wire logic [6:0] bus_target_addr,
  input wire logic       h_sync_in,
  input wire logic       v_sync_in,
  input wire logic       sync_triplet_h,
  input wire logic       sync_triplet_v,
  input wire logic       audio_frame_pulse_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ------
  // Flags
  // ------
  AST_LOCK_CLEAR: assert property (&pll_lock_bits |=> !no_lock)
    else $error("unlock flag high with every PLL locked");
  AST_ALIGN_FLAG: assert property (presetn |=> no_align == !$past(&frame_align_ok))
    else $error("misalignment flag wrong one cycle after cause");
  AST_REF_FLAG: assert property (presetn |=> no_ref == !$past(ref_valid))
    else $error("reference flag wrong one cycle after cause");
  // Strap decode, three edges after release: two sync stages, then the capture
  AST_TARGET: assert property ($past(presetn, 3) |-> bus_target_addr ==
    (addr_sel_oe_n ? CPS_ADDR_FLOAT : addr_sel_in ? CPS_ADDR_HIGH : CPS_ADDR_LOW))
    else $error("target address does not match strap");
  // ------
  // Pins
  // ------
  AST_TRIG_PULSE: assert property ($rose(align_trig_in) |-> ##[2:5] align_reset_pulse)
    else $error("no alignment reset after trigger rise");
  AST_PULSE_ONE: assert property (align_reset_pulse |=> !align_reset_pulse)
    else $error("alignment reset longer than one cycle");
  // Polarity cancels in the xor, so only the synchroniser path is seen
  AST_SYNC_XOR: assert property ($stable(h_sync_in ^ v_sync_in) [*4] |->
    (sync_triplet_h ^ sync_triplet_v) == (h_sync_in ^ v_sync_in))
    else $error("sync pair not corrected by one common polarity");
  AST_FRAME_WIDTH: assert property ($fell(audio_frame_pulse_out) |=>
    !audio_frame_pulse_out [*4] ##1 audio_frame_pulse_out)
    else $error("frame pulse not five cycles low");
  cover property ($rose(no_lock));
  cover property (align_reset_pulse);
  cover property ($fell(audio_frame_pulse_out));
endmodule

bind cps_top cps_props u_cps_props (.pclk, .presetn, .pll_lock_bits, .frame_align_ok,
  .ref_valid, .no_lock, .no_align, .no_ref, .align_trig_in, .align_reset_pulse,
  .addr_sel_in, .addr_sel_oe_n, .bus_target_addr, .h_sync_in, .v_sync_in,
  .sync_triplet_h, .sync_triplet_v, .audio_frame_pulse_out);
`default_nettype wire

// ### verification/test_clockgen_pin_control_status.sv
`default_nettype none
module test_clockgen_pin_control_status
  import cps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, run, err;
  logic        addr_sel_in, addr_sel_oe_n, h_sync_in, v_sync_in, f_sync_in;
  logic        align_trig_in, ref_valid, audio_pll_clk_tick, aux_osc_in;
  logic        audio_frame_pulse_out, audio_frame_pulse_oe_n, audio_clock_out;
  logic        aux_clock_tick, sync_triplet_h, sync_triplet_v, sync_triplet_f;
  logic        align_reset_pulse, no_lock, no_align, no_ref, aclk_q, frame_q;
  logic [3:0]  pstrb, pll_lock_bits, frame_align_ok;
  logic [6:0]  bus_target_addr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, c0, bad_count, checked, cyc, n_pul, n_fall, n_tick, n_tog;

  cps_top u_cps_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .irq, .addr_sel_in, .addr_sel_oe_n, .h_sync_in, .v_sync_in,
    .f_sync_in, .align_trig_in, .pll_lock_bits, .frame_align_ok, .ref_valid,
    .audio_pll_clk_tick, .aux_osc_in, .audio_frame_pulse_out, .audio_frame_pulse_oe_n,
    .audio_clock_out, .aux_clock_tick, .sync_triplet_h, .sync_triplet_v, .sync_triplet_f,
    .align_reset_pulse, .no_lock, .no_align, .no_ref, .bus_target_addr);
  cps_far_end u_cps_far_end (.run, .aux_osc_in);

  always #10 pclk = ~pclk;

  // Event counters and the hang guard
  always @(posedge pclk) begin
    cyc     <= cyc + 1;
    n_pul   <= n_pul + 32'(align_reset_pulse);
    n_fall  <= n_fall + 32'(frame_q & ~audio_frame_pulse_out);
    n_tick  <= n_tick + 32'(aux_clock_tick);
    n_tog   <= n_tog + 32'(aclk_q ^ audio_clock_out);
    aclk_q  <= audio_clock_out;
    frame_q <= audio_frame_pulse_out;
    if (cyc == 32'd6000) begin
      bad_count = bad_count + 1;
      results();
    end
  end

  // ------
  // Tasks
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked = checked + 1;
    if (seen !== want) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // Rates sampled over a window may be off by one edge
  task automatic near(input logic [31:0] seen, input logic [31:0] want);
    check(32'(seen + 1 >= want && seen <= want + 1), 32'd1);
  endtask
  // APB transfer; read data and error are taken at the edge that completes it
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
    bus(1'b0, a, 32'h0);
    check(rd, want);
  endtask
  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask
  task automatic reset_with(input logic in, input logic oe_n);
    addr_sel_in   <= in;
    addr_sel_oe_n <= oe_n;
    presetn       <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Strap lands three edges after release; look one edge later
    repeat (4) @(posedge pclk);
  endtask
  task automatic results;
    $display("mismatches %0d comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked != 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ------
  // Sequence
  // ------
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, align_trig_in, run} = '0;
    {bad_count, checked, cyc, n_pul, n_fall, n_tick, n_tog, aclk_q, frame_q} = '0;
    {h_sync_in, v_sync_in, f_sync_in, ref_valid, audio_pll_clk_tick} = 5'b10011;
    {pstrb, pll_lock_bits, frame_align_ok} = 12'hfff;
    {addr_sel_in, addr_sel_oe_n} = 2'b00;
    reset_with(1'b1, 1'b0);
    check(32'(bus_target_addr), 32'(CPS_ADDR_HIGH));
    reset_with(1'b0, 1'b1);
    check(32'(bus_target_addr), 32'(CPS_ADDR_FLOAT));
    reset_with(1'b0, 1'b0);
    rdchk(CPS_OFF_ADDR, 32'(CPS_ADDR_LOW));
    bus(1'b1, CPS_OFF_FRAME, 32'h10);
    rdchk(CPS_OFF_ACLK, 32'h2);
    rdchk(CPS_OFF_CTRL, 32'h0);
    rdchk(8'h20, 32'h0);
    check(32'(err), 32'd1);
    // Masked PLL must drop out of the unlock flag
    pll_lock_bits <= 4'hb;
    settle();
    check(32'(no_lock), 32'd1);
    bus(1'b1, CPS_OFF_LOCKMASK, 32'h4);
    settle();
    check(32'(no_lock), 32'd0);
    pll_lock_bits <= 4'hf;
    bus(1'b1, CPS_OFF_LOCKMASK, 32'h0);
    frame_align_ok <= 4'h7;
    ref_valid      <= 1'b0;
    settle();
    check({30'd0, no_align, no_ref}, 32'd3);
    frame_align_ok <= 4'hf;
    ref_valid      <= 1'b1;
    settle();
    check({29'd0, no_lock, no_align, no_ref}, 32'd0);
    // Sticky status, W1C, mask gating the level output
    rdchk(CPS_OFF_IRQ_STAT, 32'h7);
    bus(1'b1, CPS_OFF_IRQ_STAT, 32'h7);
    rdchk(CPS_OFF_IRQ_STAT, 32'h0);
    bus(1'b1, CPS_OFF_IRQ_MASK, 32'h1);
    pll_lock_bits <= 4'he;
    settle();
    pll_lock_bits <= 4'hf;
    settle();
    check(32'(irq), 32'd1);
    bus(1'b1, CPS_OFF_IRQ_STAT, 32'h1);
    settle();
    check(32'(irq), 32'd0);
    // Held trigger level must not fire a second time
    c0 = n_pul;
    align_trig_in <= 1'b1;
    repeat (20) @(posedge pclk);
    check(n_pul - c0, 32'd1);
    h_sync_in <= 1'b0;
    v_sync_in <= 1'b1;
    repeat (300) @(posedge pclk);
    check({29'd0, sync_triplet_h, sync_triplet_v, sync_triplet_f}, 32'd5);
    rdchk(CPS_OFF_STATUS, 32'hf8);
    h_sync_in <= 1'b1;
    repeat (10) @(posedge pclk);
    check({29'd0, sync_triplet_h, sync_triplet_v, sync_triplet_f}, 32'd6);
    c0 = n_tog;
    repeat (64) @(posedge pclk);
    near(n_tog - c0, 32'd16);
    bus(1'b1, CPS_OFF_ACLK, 32'h0);
    c0 = n_tog;
    repeat (64) @(posedge pclk);
    near(n_tog - c0, 32'd64);
    c0 = n_fall;
    repeat (160) @(posedge pclk);
    near(n_fall - c0, 32'd10);
    check(32'(audio_frame_pulse_oe_n), 32'd0);
    run <= 1'b1;
    bus(1'b1, CPS_OFF_CTRL, 32'h1);
    settle();
    check(32'(audio_frame_pulse_oe_n), 32'd1);
    c0 = n_tick;
    repeat (160) @(posedge pclk);
    near(n_tick - c0, 32'd20);
    // Frame output off: wait out a pulse first so none is cut short
    c0 = n_fall;
    while (n_fall == c0) @(posedge pclk);
    repeat (6) @(posedge pclk);
    bus(1'b1, CPS_OFF_CTRL, 32'h31);
    c0 = n_fall;
    repeat (160) @(posedge pclk);
    check(n_fall - c0, 32'd0);
    check(32'(audio_frame_pulse_out), 32'd1);
    results();
  end
endmodule
`default_nettype wire
